/* File: src/psr_soft_reset.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - writes to peripheral register pass only capability mask two bits
// RQ2 - writes to io port register pass only capability mask four bits
// RQ3 - bits 18,17,16 reset timer modules two, one, zero
// RQ4 - bit 12 resets two-wire unit, bit 4 resets synchronous serial unit
// RQ5 - bit 1 resets async serial port one, bit 0 port zero
// RQ6 - io port register bits 4..0 reset ports e, d, c, b, a
// RQ7 - unused bits are read-only and read zero
// RQ8 - software preserves unused bits on read-modify-write and ignores them
// RQ9 - both registers clear to zero on system reset
// RQ10 - a set control bit holds its peripheral in reset, clear releases
// RQ11 - a masked write bit leaves the control bit unchanged
module psr_soft_reset (
   input  wire logic                        clock,
   input  wire logic                        resetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [31:0]                 capability_mask_two,
   input  wire logic [31:0]                 capability_mask_four,
   output psr_pkg::psr_periph_rst_type      periph_rst,
   output psr_pkg::psr_io_rst_type          io_rst
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [31:0] peripheral_soft_reset_one;
   logic [31:0] io_port_soft_reset;
   logic [31:0] next_peripheral_soft_reset_one;
   logic [31:0] next_io_port_soft_reset;
   logic [31:0] next_prdata;
   logic        access;
   logic        hit_one;
   logic        hit_io;

   // masked merge of old value and write data
   function automatic logic [31:0] masked_write(
      input logic [31:0] old_val,
      input logic [31:0] data,
      input logic [31:0] mask
   );
      masked_write = (old_val & ~mask) | (data & mask);
   endfunction

   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign hit_one = (paddr == psr_pkg::off_periph_one);
   assign hit_io  = (paddr == psr_pkg::off_io_port);
   assign pslverr = access & ~hit_one & ~hit_io;

   // ------------------------------------------------------------
   // next value
   // ------------------------------------------------------------
   always_comb begin
      next_peripheral_soft_reset_one = peripheral_soft_reset_one;
      next_io_port_soft_reset        = io_port_soft_reset;
      next_prdata                    = prdata;
      if (access && pwrite && hit_one) begin
         next_peripheral_soft_reset_one = masked_write(
            peripheral_soft_reset_one, pwdata,
            capability_mask_two & psr_pkg::periph_one_bits); // RQ1 RQ7 RQ11
      end else if (access && pwrite && hit_io) begin
         next_io_port_soft_reset = masked_write(
            io_port_soft_reset, pwdata,
            capability_mask_four & psr_pkg::io_port_bits); // RQ2 RQ7 RQ11
      end
      if (psel && !penable && !pwrite) begin
         if (hit_one) begin
            next_prdata = peripheral_soft_reset_one;
         end else if (hit_io) begin
            next_prdata = io_port_soft_reset;
         end else begin
            next_prdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         peripheral_soft_reset_one <= psr_pkg::rst_periph_one; // RQ9
         io_port_soft_reset        <= psr_pkg::rst_io_port; // RQ9
         prdata                    <= 32'h0000_0000;
      end else begin
         peripheral_soft_reset_one <= next_peripheral_soft_reset_one;
         io_port_soft_reset        <= next_io_port_soft_reset;
         prdata                    <= next_prdata;
      end
   end

   // ------------------------------------------------------------
   // reset outputs
   // ------------------------------------------------------------
   always_comb begin
      periph_rst.gp_timer_module_two_rst =
         peripheral_soft_reset_one[psr_pkg::pos_timer_two]; // RQ3 RQ10
      periph_rst.gp_timer_module_one_rst =
         peripheral_soft_reset_one[psr_pkg::pos_timer_one]; // RQ3
      periph_rst.gp_timer_module_zero_rst =
         peripheral_soft_reset_one[psr_pkg::pos_timer_zero]; // RQ3
      periph_rst.two_wire_unit_zero_rst =
         peripheral_soft_reset_one[psr_pkg::pos_two_wire]; // RQ4
      periph_rst.sync_serial_zero_rst =
         peripheral_soft_reset_one[psr_pkg::pos_sync_ser]; // RQ4
      periph_rst.async_serial_one_rst =
         peripheral_soft_reset_one[psr_pkg::pos_async_one]; // RQ5
      periph_rst.async_serial_zero_rst =
         peripheral_soft_reset_one[psr_pkg::pos_async_zero]; // RQ5
      io_rst = io_port_soft_reset[4:0]; // RQ6 RQ10
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_one_reserved_zero: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      (peripheral_soft_reset_one & ~psr_pkg::periph_one_bits) == 32'h0)
      else $error("reserved bits set in peripheral register");

   a_io_reserved_zero: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      (io_port_soft_reset & ~psr_pkg::io_port_bits) == 32'h0)
      else $error("reserved bits set in io port register");

   a_one_write_mask: assert property ( // RQ1
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one |=>
      ((peripheral_soft_reset_one ^ $past(pwdata))
       & $past(capability_mask_two) & psr_pkg::periph_one_bits) == 32'h0)
      else $error("permitted peripheral bit not written");

   a_io_write_mask: assert property ( // RQ2
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_io |=>
      ((io_port_soft_reset ^ $past(pwdata))
       & $past(capability_mask_four) & psr_pkg::io_port_bits) == 32'h0)
      else $error("permitted io bit not written");

   a_one_masked_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      1'b1 |=> ((peripheral_soft_reset_one
                 ^ $past(peripheral_soft_reset_one))
                & ~$past(capability_mask_two)) == 32'h0)
      else $error("masked peripheral bit changed");

   a_io_masked_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      1'b1 |=> ((io_port_soft_reset ^ $past(io_port_soft_reset))
                & ~$past(capability_mask_four)) == 32'h0)
      else $error("masked io bit changed");

   a_timer_two_out: assert property ( // RQ3 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_timer_two]
      |=> periph_rst.gp_timer_module_two_rst
          == $past(pwdata[psr_pkg::pos_timer_two]))
      else $error("timer two reset does not follow write");

   a_read_back: assert property ( // RQ10
      @(posedge clock) disable iff (!resetn)
      psel && !penable && !pwrite && hit_io
      |=> prdata[4:0] == $past(io_rst))
      else $error("io port read data wrong");

   // ------------------------------------------------------------
   // reset output checks
   // ------------------------------------------------------------

   a_timer_one_out: assert property ( // RQ3 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_timer_one]
      |=> periph_rst.gp_timer_module_one_rst
          == $past(pwdata[psr_pkg::pos_timer_one]))
      else $error("timer one reset does not follow write");

   a_timer_zero_out: assert property ( // RQ3 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_timer_zero]
      |=> periph_rst.gp_timer_module_zero_rst
          == $past(pwdata[psr_pkg::pos_timer_zero]))
      else $error("timer zero reset does not follow write");

   a_two_wire_out: assert property ( // RQ4 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_two_wire]
      |=> periph_rst.two_wire_unit_zero_rst
          == $past(pwdata[psr_pkg::pos_two_wire]))
      else $error("two-wire reset does not follow write");

   a_sync_ser_out: assert property ( // RQ4 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_sync_ser]
      |=> periph_rst.sync_serial_zero_rst
          == $past(pwdata[psr_pkg::pos_sync_ser]))
      else $error("sync serial reset does not follow write");

   a_async_one_out: assert property ( // RQ5 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_async_one]
      |=> periph_rst.async_serial_one_rst
          == $past(pwdata[psr_pkg::pos_async_one]))
      else $error("async one reset does not follow write");

   a_async_zero_out: assert property ( // RQ5 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && capability_mask_two[psr_pkg::pos_async_zero]
      |=> periph_rst.async_serial_zero_rst
          == $past(pwdata[psr_pkg::pos_async_zero]))
      else $error("async zero reset does not follow write");

   a_io_out_follow: assert property ( // RQ6 RQ10
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_io
      |=> ((io_rst ^ $past(pwdata[4:0]))
           & $past(capability_mask_four[4:0])) == 5'h00)
      else $error("io reset outputs do not follow write");

   a_timer_zero_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && !capability_mask_two[psr_pkg::pos_timer_zero]
      |=> $stable(periph_rst.gp_timer_module_zero_rst))
      else $error("masked timer zero reset changed");

   a_two_wire_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && !capability_mask_two[psr_pkg::pos_two_wire]
      |=> $stable(periph_rst.two_wire_unit_zero_rst))
      else $error("masked two-wire reset changed");

   a_sync_ser_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && !capability_mask_two[psr_pkg::pos_sync_ser]
      |=> $stable(periph_rst.sync_serial_zero_rst))
      else $error("masked sync serial reset changed");

   a_async_zero_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_one
      && !capability_mask_two[psr_pkg::pos_async_zero]
      |=> $stable(periph_rst.async_serial_zero_rst))
      else $error("masked async zero reset changed");

   a_io_a_hold: assert property ( // RQ11
      @(posedge clock) disable iff (!resetn)
      access && pwrite && hit_io
      && !capability_mask_four[0]
      |=> $stable(io_rst.io_port_a_rst))
      else $error("masked io port a reset changed");

   // ------------------------------------------------------------
   // read path checks
   // ------------------------------------------------------------

   a_read_one: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      psel && !penable && !pwrite && hit_one
      |=> prdata == $past(peripheral_soft_reset_one))
      else $error("peripheral read data wrong");

   a_read_unmapped: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      psel && !penable && !pwrite
      && paddr != psr_pkg::off_periph_one && paddr != psr_pkg::off_io_port
      |=> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");

   a_read_reserved: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      (prdata & ~(psr_pkg::periph_one_bits | psr_pkg::io_port_bits))
      == 32'h0000_0000)
      else $error("reserved read bits not zero");

   a_rdata_hold: assert property ( // RQ7
      @(posedge clock) disable iff (!resetn)
      !(psel && !penable && !pwrite)
      |=> $stable(prdata))
      else $error("read data changed outside read setup");

   // ------------------------------------------------------------
   // register hold checks
   // ------------------------------------------------------------

   a_one_no_write: assert property ( // RQ1
      @(posedge clock) disable iff (!resetn)
      !(access && pwrite && hit_one)
      |=> $stable(peripheral_soft_reset_one))
      else $error("peripheral register changed without write");

   a_io_no_write: assert property ( // RQ2
      @(posedge clock) disable iff (!resetn)
      !(access && pwrite && hit_io)
      |=> $stable(io_port_soft_reset))
      else $error("io port register changed without write");

endmodule

/* File: src/psr_pkg.sv */
package psr_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] off_periph_one = 12'h044;
   localparam logic [11:0] off_io_port    = 12'h048;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int pos_timer_two  = 18;
   localparam int pos_timer_one  = 17;
   localparam int pos_timer_zero = 16;
   localparam int pos_two_wire   = 12;
   localparam int pos_sync_ser   = 4;
   localparam int pos_async_one  = 1;
   localparam int pos_async_zero = 0;

   // writable bits of each register
   localparam logic [31:0] periph_one_bits = 32'h0007_1013;
   localparam logic [31:0] io_port_bits    = 32'h0000_001f;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] rst_periph_one = 32'h0000_0000;
   localparam logic [31:0] rst_io_port    = 32'h0000_0000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic gp_timer_module_two_rst;
      logic gp_timer_module_one_rst;
      logic gp_timer_module_zero_rst;
      logic two_wire_unit_zero_rst;
      logic sync_serial_zero_rst;
      logic async_serial_one_rst;
      logic async_serial_zero_rst;
   } psr_periph_rst_type;

   typedef struct packed {
      logic io_port_e_rst;
      logic io_port_d_rst;
      logic io_port_c_rst;
      logic io_port_b_rst;
      logic io_port_a_rst;
   } psr_io_rst_type;

endpackage

/* File: testbench/psr_soft_reset_tb.sv */
`timescale 1ns/1ps
module psr_soft_reset_tb;
   // ------
   // signals
   // ------
   logic                        clock      = 1'b0;
   logic                        resetn     = 1'b0;
   logic                        psel       = 1'b0;
   logic                        penable    = 1'b0;
   logic                        pwrite     = 1'b0;
   logic [11:0]                 paddr      = 12'h000;
   logic [31:0]                 pwdata     = 32'h0;
   logic [31:0]                 mask_two   = 32'hffff_ffff;
   logic [31:0]                 mask_four  = 32'hffff_ffff;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   psr_pkg::psr_periph_rst_type periph_rst;
   psr_pkg::psr_io_rst_type     io_rst;
   logic [31:0]                 m1, m2, rd, d, k;
   logic                        se;
   logic [31:0]                 b, e, wm;
   logic [11:0]                 ad;
   int                          wt         = 0;
   int                          err_count  = 0;
   int                          n_compared = 0;
   int                          cycles     = 0;
   int                          seed       = 32'h528c;

   always #12.5 clock = ~clock;

   psr_soft_reset uut (.clock(clock), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capability_mask_two(mask_two), .capability_mask_four(mask_four),
      .periph_rst(periph_rst), .io_rst(io_rst));

   // ------
   // tasks
   // ------
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task check_outs;
      e = {25'h0, m1[18:16], m1[12], m1[4], m1[1:0]};
      chk({25'h0, periph_rst}, e);
      chk({27'h0, io_rst}, {27'h0, m2[4:0]});
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      wt = 0;
      while (pready !== 1'b1) begin
         wt++;
         @(posedge clock);
      end
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task step(input logic [11:0] a, input logic [31:0] wd);
      logic bad;
      bad = (a != psr_pkg::off_periph_one) && (a != psr_pkg::off_io_port);
      apb(1'b1, a, wd);
      chk({31'h0, se}, {31'h0, bad});
      chk(wt, 32'h0);
      if (a == psr_pkg::off_periph_one) begin
         b  = mask_two & psr_pkg::periph_one_bits;
         m1 = (m1 & ~b) | (wd & b);
      end
      if (a == psr_pkg::off_io_port) begin
         b  = mask_four & psr_pkg::io_port_bits;
         m2 = (m2 & ~b) | (wd & b);
      end
      #1;
      check_outs();
      apb(1'b0, a, 32'h0);
      chk(wt, 32'h0);
      chk(rd, bad ? 32'h0 : (a == psr_pkg::off_io_port ? m2 : m1));
      chk({31'h0, se}, {31'h0, bad});
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      m1 = 32'h0;
      m2 = 32'h0;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      #1;
      check_outs();
      step(psr_pkg::off_periph_one, 32'hffff_ffff);
      step(psr_pkg::off_io_port, 32'hffff_ffff);
      repeat (60) begin
         mask_two  <= $random(seed);
         mask_four <= $random(seed);
         d = $random(seed);
         k = $random(seed);
         ad = k[0] ? psr_pkg::off_periph_one
              : (k[1] ? psr_pkg::off_io_port : 12'h04c);
         wm = (ad == psr_pkg::off_io_port) ? psr_pkg::io_port_bits
              : psr_pkg::periph_one_bits;
         step(ad, d & wm);
      end
      mask_two <= 32'h0;
      step(psr_pkg::off_periph_one, ~m1 & psr_pkg::periph_one_bits);
      @(posedge clock);
      resetn <= 1'b0;
      m1 = 32'h0;
      m2 = 32'h0;
      #1;
      check_outs();
      @(posedge clock);
      resetn <= 1'b1;
      apb(1'b0, psr_pkg::off_io_port, 32'h0);
      chk(rd, 32'h0);
      summarize();
   end
endmodule
